// ===== txdma_pkg.sv
// Shared constants, types and register map of the transmit channel state block
package txdma_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_QUEUE_FRONT = 8'h00;
    localparam logic [7:0] OFF_SOP_DESC = 8'h04;
    localparam logic [7:0] OFF_CURR_DESC = 8'h08;
    localparam logic [7:0] OFF_BUF_ADDR = 8'h0c;
    localparam logic [7:0] OFF_BUF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_PKT_LEN = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
    // Field positions
    localparam int PTR_LSB = 2;
    localparam int IN_PKT_BIT = 0;
    localparam int CUT_BIT = 1;
    localparam int TAG_LSB = 24;
    localparam int LAST_BIT = 17;
    localparam int FIRST_BIT = 16;
    localparam int REM_LSB = 16;
    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // Interrupt events
    localparam int IRQ_BITS = 3;
    localparam int EV_PKT_START = 0;
    localparam int EV_PKT_DONE = 1;
    localparam int EV_CUT = 2;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // Start-of-packet descriptor fields handed in by the fetch logic
    typedef struct packed {
        logic [29:0] desc_ptr;
        logic [31:0] buf_addr;
        logic [15:0] buf_len;
        logic [15:0] pkt_len;
        logic [7:0] tag;
        logic last;
    } sop_desc_type;

    // Follow-on buffer descriptor fields
    typedef struct packed {
        logic [29:0] desc_ptr;
        logic [31:0] buf_addr;
        logic [15:0] buf_len;
        logic last;
    } next_desc_type;

    // Channel states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_WAIT = 3'b100
    } chan_state_type;
endpackage

// ===== txdma_regfile.sv
// Read-data mux register for the channel state words
`timescale 1ns/10ps
module txdma_regfile #(
    parameter int WORDS = 9
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Lookup
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [WORDS*32-1:0] words_i,
    // Answer
    output logic [31:0] rdata_o
);
    // Elaboration check: the six-bit word index serves at most 64 words
    if (WORDS < 1 || WORDS > 64) begin : g_words_check
        $error("WORDS out of range");
    end
    logic [31:0] pick; // Selected word
    // Pick the word at the aligned index, unmapped reads as zero
    always_comb begin
        pick = 32'h0000_0000;
        if (addr_i[1:0] == 2'h0 && 32'(addr_i[7:2]) < WORDS) begin
            pick = words_i[addr_i[7:2]*32 +: 32];
        end
    end
    // Read data registered, valid in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= pick;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule

// ===== txdma_chan.sv
// Transmit channel state words of a descriptor-driven DMA engine
//
// Behaviour
// [RULE1] Word one bits 31:2 hold first-descriptor pointer
// [RULE2] Word one bit 0 marks packet in progress
// [RULE3] Word two bits 31:2 hold active descriptor
// [RULE4] Word two bit 1 flags early cut
// [RULE5] Word three holds active byte address
// [RULE6] Word four bits 31:24 carry tag byte
// [RULE7] Word four bit 17 marks last buffer
// [RULE8] Word four bit 16 marks first buffer
// [RULE9] Word four bits 15:0 hold buffer bytes left
// [RULE10] Word five bits 31:16 hold bytes before cut
// [RULE11] Word five bits 15:0 loaded from packet length
// [RULE12] Packet length goes into the trailer
// [RULE13] Word zero bits 31:2 hold queue front pointer
// [RULE14] Software writes state only while idle; the code takes writes in any state, below hardware updates
`timescale 1ns/10ps
module txdma_chan
    import txdma_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Register port
    input wire txdma_pkg::reg_req_type REG_REQ_I,
    output logic [31:0] REG_RDATA_O,
    // Descriptor fetch side
    input wire logic SOP_VALID_I,
    input wire txdma_pkg::sop_desc_type SOP_DESC_I,
    input wire logic NEXT_VALID_I,
    input wire txdma_pkg::next_desc_type NEXT_DESC_I,
    output logic NEED_DESC_O,
    // Endpoint byte side
    input wire logic BYTE_TAKE_I,
    output logic BYTE_REQ_O,
    output logic [31:0] BYTE_ADDR_O,
    output logic BYTE_LAST_O,
    // Trailer and tag out
    output logic TRAILER_VALID_O,
    output logic [15:0] TRAILER_LEN_O,
    output logic [7:0] TAG_OUT_O,
    // Interrupt
    output logic IRQ_O
);
    import txdma_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State words
    logic [29:0] queue_front_pointer; // Head of high-priority queue
    logic [29:0] first_desc_pointer; // First descriptor of packet
    logic in_packet; // Packet in progress
    logic [29:0] active_desc_pointer; // Descriptor being sent from
    logic early_cut_flag; // Cut inside non-last buffer
    logic [31:0] active_byte_address; // Byte being read
    logic [7:0] tag_byte; // Packet tag
    logic last_buffer_flag; // Current buffer is last
    logic first_buffer_flag; // Current buffer is first
    logic [15:0] buffer_bytes_left; // Bytes left in buffer
    logic [15:0] bytes_before_cut; // Bytes left before cut
    logic [15:0] packet_length; // Whole packet length
    chan_state_type state; // Channel sequencer
    logic [IRQ_BITS-1:0] irq_status; // Sticky events
    logic [IRQ_BITS-1:0] irq_enable; // Event enables
    logic [IRQ_BITS-1:0] events; // One-cycle events

    logic wr; // Software write strobe, not gated by state
    logic take; // A byte leaves this cycle
    logic buf_end; // Byte taken is last of buffer
    logic cut_now; // Byte taken is last before cut
    logic pkt_end; // Packet ends this cycle

    assign wr = REG_REQ_I.wr;
    assign take = (state == ST_SEND) && BYTE_TAKE_I;
    assign buf_end = take && (buffer_bytes_left == 16'h0001);
    assign cut_now = take && (bytes_before_cut == 16'h0001);
    assign pkt_end = cut_now || (buf_end && last_buffer_flag);

    ////////////////////////////////////////////////////////////////////////////
    // Channel sequencer
    // Idle waits for a start descriptor, send moves bytes, wait fetches more
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (SOP_VALID_I) begin
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (pkt_end) begin
                        state <= ST_IDLE;
                    end else if (buf_end) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (NEXT_VALID_I) begin
                        state <= ST_SEND;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word zero: queue front, software owned
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            queue_front_pointer <= RESET_WORD[31:PTR_LSB];
        end else if (wr && REG_REQ_I.addr == OFF_QUEUE_FRONT) begin
            queue_front_pointer <= REG_REQ_I.wdata[31:PTR_LSB]; // RULE13
        end
    end

    // Word one: first descriptor pointer and in-packet flag
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            first_desc_pointer <= RESET_WORD[31:PTR_LSB];
            in_packet <= 1'b0;
        end else if (state == ST_IDLE && SOP_VALID_I) begin
            first_desc_pointer <= SOP_DESC_I.desc_ptr; // RULE1
            in_packet <= 1'b1; // RULE2
        end else if (pkt_end) begin
            in_packet <= 1'b0; // RULE2
        end else if (wr && REG_REQ_I.addr == OFF_SOP_DESC) begin
            first_desc_pointer <= REG_REQ_I.wdata[31:PTR_LSB]; // RULE14
            in_packet <= REG_REQ_I.wdata[IN_PKT_BIT];
        end
    end

    // Word two: active descriptor and early cut flag
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            active_desc_pointer <= RESET_WORD[31:PTR_LSB];
            early_cut_flag <= 1'b0;
        end else if (state == ST_IDLE && SOP_VALID_I) begin
            active_desc_pointer <= SOP_DESC_I.desc_ptr; // RULE3
            early_cut_flag <= 1'b0;
        end else if (state == ST_WAIT && NEXT_VALID_I) begin
            active_desc_pointer <= NEXT_DESC_I.desc_ptr; // RULE3
        end else if (cut_now && !last_buffer_flag) begin
            // Only a cut inside a buffer not marked last counts
            early_cut_flag <= 1'b1; // RULE4
        end else if (wr && REG_REQ_I.addr == OFF_CURR_DESC) begin
            active_desc_pointer <= REG_REQ_I.wdata[31:PTR_LSB];
            early_cut_flag <= REG_REQ_I.wdata[CUT_BIT];
        end
    end

    // Word three: byte address, advances per byte taken
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            active_byte_address <= RESET_WORD;
        end else if (state == ST_IDLE && SOP_VALID_I) begin
            active_byte_address <= SOP_DESC_I.buf_addr; // RULE5
        end else if (state == ST_WAIT && NEXT_VALID_I) begin
            active_byte_address <= NEXT_DESC_I.buf_addr; // RULE5
        end else if (take) begin
            active_byte_address <= active_byte_address + 32'h0000_0001; // RULE5
        end else if (wr && REG_REQ_I.addr == OFF_BUF_ADDR) begin
            active_byte_address <= REG_REQ_I.wdata;
        end
    end

    // Word four: tag, buffer flags, bytes left in buffer
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tag_byte <= 8'h00;
            last_buffer_flag <= 1'b0;
            first_buffer_flag <= 1'b0;
            buffer_bytes_left <= 16'h0000;
        end else if (state == ST_IDLE && SOP_VALID_I) begin
            tag_byte <= SOP_DESC_I.tag; // RULE6
            last_buffer_flag <= SOP_DESC_I.last; // RULE7
            first_buffer_flag <= 1'b1; // RULE8
            buffer_bytes_left <= SOP_DESC_I.buf_len; // RULE9
        end else if (state == ST_WAIT && NEXT_VALID_I) begin
            last_buffer_flag <= NEXT_DESC_I.last; // RULE7
            first_buffer_flag <= 1'b0; // RULE8
            buffer_bytes_left <= NEXT_DESC_I.buf_len; // RULE9
        end else if (take) begin
            buffer_bytes_left <= buffer_bytes_left - 16'h0001; // RULE9
        end else if (wr && REG_REQ_I.addr == OFF_BUF_FLAGS) begin
            tag_byte <= REG_REQ_I.wdata[31:TAG_LSB];
            last_buffer_flag <= REG_REQ_I.wdata[LAST_BIT];
            first_buffer_flag <= REG_REQ_I.wdata[FIRST_BIT];
            buffer_bytes_left <= REG_REQ_I.wdata[15:0];
        end
    end

    // Word five: bytes before cut and packet length
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            bytes_before_cut <= 16'h0000;
            packet_length <= 16'h0000;
        end else if (state == ST_IDLE && SOP_VALID_I) begin
            bytes_before_cut <= SOP_DESC_I.pkt_len; // RULE10
            packet_length <= SOP_DESC_I.pkt_len; // RULE11
        end else if (take) begin
            bytes_before_cut <= bytes_before_cut - 16'h0001; // RULE10
        end else if (wr && REG_REQ_I.addr == OFF_PKT_LEN) begin
            bytes_before_cut <= REG_REQ_I.wdata[31:REM_LSB];
            packet_length <= REG_REQ_I.wdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trailer: packet length handed out as the packet closes
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            TRAILER_VALID_O <= 1'b0;
            TRAILER_LEN_O <= 16'h0000;
        end else begin
            TRAILER_VALID_O <= pkt_end;
            if (pkt_end) begin
                TRAILER_LEN_O <= packet_length; // RULE12
            end
        end
    end

    // Byte side outputs
    assign BYTE_REQ_O = (state == ST_SEND);
    assign BYTE_LAST_O = pkt_end;
    assign NEED_DESC_O = (state == ST_WAIT);
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            BYTE_ADDR_O <= 32'h0000_0000;
            TAG_OUT_O <= 8'h00;
        end else begin
            BYTE_ADDR_O <= active_byte_address;
            TAG_OUT_O <= tag_byte; // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, set wins over clear
    assign events[EV_PKT_START] = (state == ST_IDLE) && SOP_VALID_I;
    assign events[EV_PKT_DONE] = pkt_end;
    assign events[EV_CUT] = cut_now && !last_buffer_flag; // RULE4
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_status <= '0;
        end else begin
            for (int i = 0; i < IRQ_BITS; i++) begin
                if (events[i]) begin
                    irq_status[i] <= 1'b1;
                end else if (wr && REG_REQ_I.addr == OFF_IRQ_CLEAR && REG_REQ_I.wdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end
    // Enable register
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_enable <= '0;
        end else if (wr && REG_REQ_I.addr == OFF_IRQ_ENABLE) begin
            irq_enable <= REG_REQ_I.wdata[IRQ_BITS-1:0];
        end
    end
    assign IRQ_O = |(irq_status & irq_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    logic [9*32-1:0] words; // Word images, index order
    assign words = {32'h0000_0000,
                    {29'h0, irq_enable},
                    {29'h0, irq_status},
                    {bytes_before_cut, packet_length},
                    {tag_byte, 6'h00, last_buffer_flag, first_buffer_flag, buffer_bytes_left},
                    active_byte_address,
                    {active_desc_pointer, early_cut_flag, 1'b0},
                    {first_desc_pointer, 1'b0, in_packet},
                    {queue_front_pointer, 2'h0}};
    txdma_regfile #(.WORDS(9)) u_rd (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .rd_i(REG_REQ_I.rd),
        .addr_i(REG_REQ_I.addr),
        .words_i(words),
        .rdata_o(REG_RDATA_O)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_start_loads: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE2
        (state == ST_IDLE && SOP_VALID_I) |=> in_packet && first_buffer_flag)
        else $error("start did not load packet state");
    chk_sop_ptr: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE1
        (state == ST_IDLE && SOP_VALID_I) |=>
        first_desc_pointer == $past(SOP_DESC_I.desc_ptr))
        else $error("first descriptor pointer not loaded");
    chk_end_clears: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE2
        pkt_end |=> !in_packet && state == ST_IDLE)
        else $error("packet end did not clear flag");
    chk_addr_step: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE5
        (take && !pkt_end && !buf_end) |=>
        active_byte_address == $past(active_byte_address) + 32'h0000_0001)
        else $error("byte address did not advance");
    chk_left_step: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE9
        take |=> buffer_bytes_left == $past(buffer_bytes_left) - 16'h0001)
        else $error("buffer count did not step");
    chk_cut_step: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE10
        take |=> bytes_before_cut == $past(bytes_before_cut) - 16'h0001)
        else $error("remaining count did not step");
    chk_trailer_len: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE12
        pkt_end |=> TRAILER_VALID_O && TRAILER_LEN_O == $past(packet_length))
        else $error("trailer length wrong");
    chk_early_cut: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE4
        (cut_now && !last_buffer_flag) |=> early_cut_flag)
        else $error("early cut not flagged");
    // A cut that lands in the last buffer is an ordinary end, never flagged
    chk_cut_last: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE4
        (cut_now && last_buffer_flag) |=> !early_cut_flag)
        else $error("cut in last buffer flagged");
    chk_len_load: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE11
        (state == ST_IDLE && SOP_VALID_I) |=> packet_length == $past(SOP_DESC_I.pkt_len)
        && tag_byte == $past(SOP_DESC_I.tag))
        else $error("packet length or tag not loaded");
    cov_packet: cover property (@(posedge CLK_I) disable iff (!RST_B_I) pkt_end);
    cov_second_buf: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
        state == ST_WAIT ##1 state == ST_SEND);
    cov_cut: cover property (@(posedge CLK_I) disable iff (!RST_B_I) events[EV_CUT]);
endmodule

// ===== txdma_far_model.sv
// Model of the descriptor store and endpoint byte sink beside the channel
`timescale 1ns/10ps
module txdma_far_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Control from the bench
    input wire logic stall_i,
    input wire txdma_pkg::next_desc_type desc_i,
    // Channel side
    input wire logic need_desc_i,
    output logic next_valid_o,
    output txdma_pkg::next_desc_type next_desc_o,
    output logic byte_take_o
);
    import txdma_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Offer one descriptor when asked; the offer drops after the accepting edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            next_valid_o <= 1'b0;
        end else begin
            next_valid_o <= need_desc_i && !next_valid_o;
        end
    end

    // Outside an offer the fields show garbage, not the last value
    assign next_desc_o = next_valid_o ? desc_i : ~desc_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Endpoint sink takes one byte a cycle unless stalled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            byte_take_o <= 1'b0;
        end else begin
            byte_take_o <= !stall_i;
        end
    end
endmodule

// ===== usb_tx_dma_channel_state_tb.sv
// Self-checking testbench of the transmit channel state block
`timescale 1ns/10ps
module usb_tx_dma_channel_state_tb;
    import txdma_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    reg_req_type req = '0;
    logic [31:0] rdata;
    logic sop_valid = 1'b0;
    sop_desc_type sop_desc = '0;
    logic next_valid, need, take, breq, blast, tv, irq;
    next_desc_type next_desc;
    next_desc_type far_desc = '0;
    logic stall = 1'b1;
    logic [31:0] baddr;
    logic [15:0] tlen;
    logic [7:0] tag_out;
    int taken = 0;
    int trailers = 0;
    int errors = 0;
    int checks = 0;
    logic last_seen = 1'b0;

    // Clock at 250 MHz
    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Design and far side
    txdma_chan u_dut (.CLK_I(clk), .RST_B_I(rst_b), .REG_REQ_I(req), .REG_RDATA_O(rdata),
        .SOP_VALID_I(sop_valid), .SOP_DESC_I(sop_desc), .NEXT_VALID_I(next_valid),
        .NEXT_DESC_I(next_desc), .NEED_DESC_O(need), .BYTE_TAKE_I(take), .BYTE_REQ_O(breq),
        .BYTE_ADDR_O(baddr), .BYTE_LAST_O(blast), .TRAILER_VALID_O(tv),
        .TRAILER_LEN_O(tlen), .TAG_OUT_O(tag_out), .IRQ_O(irq));
    txdma_far_model u_far (.clk_i(clk), .rst_b_i(rst_b), .stall_i(stall), .desc_i(far_desc),
        .need_desc_i(need), .next_valid_o(next_valid), .next_desc_o(next_desc),
        .byte_take_o(take));

    // Count taken bytes, trailer pulses and last-byte marks
    always @(posedge clk) begin
        if (take === 1'b1 && breq === 1'b1) taken++;
        if (tv === 1'b1) trailers++;
        if (blast === 1'b1) last_seen = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) req <= '0;
        #1;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk) req <= '0;
        #1 d = rdata;
    endtask

    task automatic start_pkt(input sop_desc_type d);
        @(posedge clk) sop_desc <= d;
        sop_valid <= 1'b1;
        @(posedge clk) sop_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wait_trailer();
        int n;
        n = trailers;
        repeat (200) begin
            @(posedge clk) #1;
            if (trailers != n) break;
        end
        check32(trailers - n, 32'h1);
    endtask

    task automatic wait_need(input logic val);
        repeat (50) begin
            @(posedge clk) #1;
            if (need === val) break;
        end
        check1(need, val);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset();
        logic [31:0] v;
        check1(breq, 1'b0);
        for (int a = 0; a <= 'h24; a += 4) begin
            reg_rd(a[7:0], v);
            check32(v, RESET_WORD);
        end
        reg_wr(OFF_IRQ_STATUS, 32'h7);
        reg_rd(OFF_IRQ_STATUS, v);
        check32(v, 32'h0);
        reg_wr(OFF_QUEUE_FRONT, 32'hdeadbeec);
        reg_rd(OFF_QUEUE_FRONT, v);
        check32(v, 32'hdeadbeec);
        reg_wr(OFF_BUF_ADDR, 32'h1234_5678);
        reg_rd(OFF_BUF_ADDR, v);
        check32(v, 32'h1234_5678);
        $display("test reset and software access done");
    endtask

    task automatic test_single();
        sop_desc_type d;
        logic [31:0] v;
        int n;
        d = '{desc_ptr: 30'h0000_1000, buf_addr: 32'h8000_0100, buf_len: 16'h0003,
            pkt_len: 16'h0003, tag: 8'h5a, last: 1'b1};
        start_pkt(d);
        reg_rd(OFF_SOP_DESC, v);
        check32(v, {d.desc_ptr, 2'b01});
        reg_rd(OFF_CURR_DESC, v);
        check32(v, {d.desc_ptr, 2'b00});
        reg_rd(OFF_BUF_ADDR, v);
        check32(v, d.buf_addr);
        reg_rd(OFF_BUF_FLAGS, v);
        check32(v, {d.tag, 6'h00, 1'b1, 1'b1, d.buf_len});
        reg_rd(OFF_PKT_LEN, v);
        check32(v, {d.pkt_len, d.pkt_len});
        check32({24'h0, tag_out}, {24'h0, d.tag});
        n = taken;
        last_seen = 1'b0;
        stall <= 1'b0;
        wait_trailer();
        stall <= 1'b1;
        check32(taken - n, 32'h3);
        check32({16'h0, tlen}, {16'h0, d.pkt_len});
        check1(last_seen, 1'b1);
        reg_rd(OFF_SOP_DESC, v);
        check1(v[IN_PKT_BIT], 1'b0);
        reg_rd(OFF_CURR_DESC, v);
        check1(v[CUT_BIT], 1'b0);
        $display("test single buffer packet done");
    endtask

    task automatic test_irq();
        logic [31:0] v;
        reg_rd(OFF_IRQ_STATUS, v);
        check32(v, 32'h3);
        check1(irq, 1'b0);
        reg_wr(OFF_IRQ_ENABLE, 32'h2);
        check1(irq, 1'b1);
        reg_rd(OFF_IRQ_ENABLE, v);
        check32(v, 32'h2);
        reg_wr(OFF_IRQ_CLEAR, 32'h7);
        check1(irq, 1'b0);
        reg_rd(OFF_IRQ_STATUS, v);
        check32(v, 32'h0);
        reg_rd(OFF_IRQ_CLEAR, v);
        check32(v, 32'h0);
        $display("test interrupt done");
    endtask

    task automatic test_multi();
        sop_desc_type d;
        next_desc_type nd;
        logic [31:0] v;
        int n;
        d = '{desc_ptr: 30'h0000_1100, buf_addr: 32'h8000_0200, buf_len: 16'h0002,
            pkt_len: 16'h0005, tag: 8'ha3, last: 1'b0};
        nd = '{desc_ptr: 30'h0000_2000, buf_addr: 32'h9000_0000, buf_len: 16'h0003, last: 1'b1};
        far_desc <= nd;
        n = taken;
        start_pkt(d);
        stall <= 1'b0;
        wait_need(1'b1);
        stall <= 1'b1;
        wait_need(1'b0);
        repeat (2) @(posedge clk);
        reg_rd(OFF_SOP_DESC, v);
        check32(v, {d.desc_ptr, 2'b01});
        reg_rd(OFF_CURR_DESC, v);
        check32(v, {nd.desc_ptr, 2'b00});
        reg_rd(OFF_BUF_ADDR, v);
        check32(v, nd.buf_addr);
        check32(baddr, nd.buf_addr);
        reg_rd(OFF_BUF_FLAGS, v);
        check32(v, {d.tag, 6'h00, 1'b1, 1'b0, nd.buf_len});
        reg_rd(OFF_PKT_LEN, v);
        check32(v, {16'h0003, d.pkt_len});
        stall <= 1'b0;
        wait_trailer();
        stall <= 1'b1;
        check32(taken - n, 32'h5);
        check32({16'h0, tlen}, 32'h5);
        $display("test two buffer packet done");
    endtask

    task automatic test_cut();
        sop_desc_type d;
        logic [31:0] v;
        int n;
        d = '{desc_ptr: 30'h0000_3000, buf_addr: 32'ha000_0000, buf_len: 16'h0004,
            pkt_len: 16'h0002, tag: 8'h11, last: 1'b0};
        n = taken;
        start_pkt(d);
        stall <= 1'b0;
        wait_trailer();
        stall <= 1'b1;
        check32(taken - n, 32'h2);
        reg_rd(OFF_CURR_DESC, v);
        check1(v[CUT_BIT], 1'b1);
        reg_rd(OFF_IRQ_STATUS, v);
        check1(v[EV_CUT], 1'b1);
        check32({16'h0, tlen}, 32'h2);
        $display("test early cut done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #40000;
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        test_reset();
        test_single();
        test_irq();
        test_multi();
        test_cut();
        finish_test();
    end
endmodule
